// [src/pce_port_cfg.sv]
// module: port configuration register, port 2/3 control and port 3 edge interrupts
// What this block does
// R1: port 2 is eight bidirectional lines, direction set per bit, inputs Schmitt buffered
// R2: port 2 output lines switch together between push-pull and open-drain
// R3: port 2 resets to all inputs; optional handshake control
// R4: port 1, port 0, strobes and read/write can float for bus sharing
// R5: in ROM mode port 1 is input right after reset
// R6: port 3 mode bit 1 enables analog compare of bits 1,2 against bit 3
// R7: port 3 bits 0 and 3 interrupt on falling edge only
// R8: port 3 bits 1 and 2 interrupt on falling, rising or both edges
// R9: timer one takes input from port 3 bit 1, drives port 3 bit 6
// R10: port 3 carries handshake lines for ports 0, 1 and 2
// R11: six interrupt sources map to fixed vector pairs 0 through 11
// R12: software waits two instruction times before reading comparator after mode change
// R13: software clears interrupt requests 3 to 0 after enabling analog mode
// R14: config bit 0 routes comparator outputs to port 3 bits 4 and 7
// R15: config bit 1 selects port 1 open-drain when 0, push-pull when 1
// R16: config bit 2 selects port 0 open-drain when 0, push-pull when 1
// R17: config bits 3 to 6 select low-EMI buffers per port when 0
// R18: config bit 7 selects standard or low-noise oscillator drive
// R19: with the emulator software keeps config bit 4 at 1
// R20: reset loads every config bit with its default
// R21: low-noise oscillator drive only allowed at or below 2 MHz system clock
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module pce_port_cfg (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire pce_pkg::pce_req_s    bus_req,
  output logic [7:0]                rdata,
  input  wire logic                 rom_mode,
  input  wire logic [7:0]           p2_in,
  output logic [7:0]                p2_out,
  output logic [7:0]                p2_oe,
  input  wire logic [7:0]           p3_in,
  output logic [7:0]                p3_out,
  output logic [7:0]                p3_oe,
  input  wire logic                 cmp1_result,
  input  wire logic                 cmp2_result,
  output logic                      analog_en,
  input  wire logic                 timer1_out,
  output logic                      timer1_in,
  input  wire logic                 data_available_0,
  input  wire logic                 data_available_2,
  input  wire logic                 counter_zero,
  input  wire logic                 counter_one,
  input  wire logic [2:0]           hsk_out,
  output logic [2:0]                hsk_in,
  output logic [5:0]                irq_req,
  output logic                      irq_valid,
  output logic [3:0]                irq_vector,
  output logic [7:0]                p1_dir,
  output logic                      bus_float,
  output logic                      p0_push_pull,
  output logic                      p1_push_pull,
  output logic [3:0]                port_std_buf,
  output logic                      osc_std_drive,
  output logic                      osc_limit_err,
  input  wire logic                 sclk_above_2mhz
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] port_config_reg;
  logic [7:0] port3_mode_reg;
  logic [7:0] p2_dir;
  logic [7:0] p2_data;
  logic [7:0] p3_data;
  logic [3:0] edge_sel;
  logic [5:0] irq_pend;
  logic [5:0] irq_event;
  logic [5:0] next_irq_pend;
  logic       bus_float_reg;
  logic [7:0] next_rdata;
  logic [7:0] p3_lines;
  logic       hit0;
  logic       hit1;
  logic       hit2;
  logic       hit3;
  logic [3:0] next_vector;
  logic       wr;

  assign wr = bus_req.wr;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_config_reg <= pce_pkg::PORT_CONFIG_RST; // R20
    end else if (wr && bus_req.addr == pce_pkg::ADDR_PORT_CONFIG) begin
      port_config_reg <= bus_req.wdata; // R19
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port3_mode_reg <= pce_pkg::PORT3_MODE_RST;
      edge_sel       <= pce_pkg::EDGE_SEL_RST;
      bus_float_reg  <= 1'b0;
    end else if (wr) begin
      if (bus_req.addr == pce_pkg::ADDR_PORT3_MODE) begin
        port3_mode_reg <= bus_req.wdata; // R6
      end else if (bus_req.addr == pce_pkg::ADDR_EDGE_SEL) begin
        edge_sel <= bus_req.wdata[3:0]; // R8
      end else if (bus_req.addr == pce_pkg::ADDR_BUS_CTRL) begin
        bus_float_reg <= bus_req.wdata[0]; // R4
      end
    end
  end

  // ---------------------------------------------------------------
  // port 1 direction, port 2 direction and data, port 3 data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      p2_dir  <= pce_pkg::P2_DIR_RST; // R3
      p2_data <= 8'h00;
      p3_data <= 8'h00;
      p1_dir  <= pce_pkg::P1_DIR_RST;
    end else if (wr) begin
      if (bus_req.addr == pce_pkg::ADDR_P2_DIR) begin
        p2_dir <= bus_req.wdata; // R1
      end else if (bus_req.addr == pce_pkg::ADDR_P2_OUT) begin
        p2_data <= bus_req.wdata;
      end else if (bus_req.addr == pce_pkg::ADDR_P3_OUT) begin
        p3_data <= bus_req.wdata;
      end else if (bus_req.addr == pce_pkg::ADDR_P1_DIR && !rom_mode) begin
        p1_dir <= bus_req.wdata; // R5
      end
    end
  end

  // direction bit 1 means input; open-drain drives only the low level
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      p2_out <= 8'h00;
      p2_oe  <= 8'h00; // R3
    end else begin
      p2_out <= p2_data;
      for (int i = 0; i < 8; i++) begin
        if (port3_mode_reg[pce_pkg::P3M_P2_OD]) begin
          p2_oe[i] <= ~p2_dir[i] & ~p2_data[i] & ~bus_float_reg; // R2
        end else begin
          p2_oe[i] <= ~p2_dir[i] & ~bus_float_reg; // R1
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // port 3 special functions
  // ---------------------------------------------------------------
  // lines 4..7 are outputs, 0..3 inputs; 4 and 7 may carry comparators
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      p3_out <= 8'h00;
      p3_oe  <= 8'h00;
    end else begin
      p3_oe  <= 8'hF0;
      p3_out <= {4'h0, p3_data[3:0]};
      p3_out[5] <= port3_mode_reg[pce_pkg::P3M_HSK_EN] ? hsk_out[1] : p3_data[5]; // R10
      p3_out[6] <= timer1_out; // R9
      if (port_config_reg[pce_pkg::CFG_CMP_OUT]) begin
        p3_out[4] <= cmp1_result; // R14
        p3_out[7] <= cmp2_result; // R14
      end else begin
        p3_out[4] <= port3_mode_reg[pce_pkg::P3M_HSK_EN] ? hsk_out[0] : p3_data[4];
        p3_out[7] <= port3_mode_reg[pce_pkg::P3M_HSK_EN] ? hsk_out[2] : p3_data[7];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      p3_lines  <= 8'hFF;
      timer1_in <= 1'b0;
      hsk_in    <= 3'h0;
      analog_en <= 1'b0;
    end else begin
      p3_lines  <= p3_in;
      timer1_in <= p3_lines[1]; // R9
      hsk_in    <= {p3_lines[2], p3_lines[1], p3_lines[0]}; // R10
      analog_en <= port3_mode_reg[pce_pkg::P3M_ANALOG]; // R6
    end
  end

  // in analog mode bits 1 and 2 follow comparator results; bits 0/3 fall only
  pce_edge_det u_edge0 (.ref_clk(ref_clk), .reset_n(reset_n), .pin(p3_lines[0]),
    .mode(2'h0), .hit(hit0)); // R7
  pce_edge_det u_edge3 (.ref_clk(ref_clk), .reset_n(reset_n), .pin(p3_lines[3]),
    .mode(2'h0), .hit(hit3)); // R7
  pce_edge_det u_edge1 (.ref_clk(ref_clk), .reset_n(reset_n),
    .pin(analog_en ? cmp1_result : p3_lines[1]), .mode(edge_sel[1:0]), .hit(hit1)); // R8
  pce_edge_det u_edge2 (.ref_clk(ref_clk), .reset_n(reset_n),
    .pin(analog_en ? cmp2_result : p3_lines[2]), .mode(edge_sel[3:2]), .hit(hit2)); // R8

  // ---------------------------------------------------------------
  // interrupt requests and vectors
  // ---------------------------------------------------------------
  always_comb begin
    irq_event = {counter_one, counter_zero, hit0, hit1, hit3, hit2 | data_available_0};
    irq_event[2] = hit1 | data_available_2; // R11
    next_irq_pend = irq_pend;
    if (wr && bus_req.addr == pce_pkg::ADDR_IRQ_PEND) begin
      next_irq_pend = irq_pend & ~bus_req.wdata[5:0]; // R13
    end
    next_irq_pend = next_irq_pend | irq_event; // set wins over clear
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pend <= 6'h00;
    end else begin
      irq_pend <= next_irq_pend;
    end
  end

  always_comb begin
    next_vector = pce_pkg::VEC_IRQ0;
    if (next_irq_pend[0]) begin
      next_vector = pce_pkg::VEC_IRQ0; // R11
    end else if (next_irq_pend[1]) begin
      next_vector = pce_pkg::VEC_IRQ1;
    end else if (next_irq_pend[2]) begin
      next_vector = pce_pkg::VEC_IRQ2;
    end else if (next_irq_pend[3]) begin
      next_vector = pce_pkg::VEC_IRQ3;
    end else if (next_irq_pend[4]) begin
      next_vector = pce_pkg::VEC_IRQ4;
    end else if (next_irq_pend[5]) begin
      next_vector = pce_pkg::VEC_IRQ5;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_req    <= 6'h00;
      irq_valid  <= 1'b0;
      irq_vector <= pce_pkg::VEC_IRQ0;
    end else begin
      irq_req    <= next_irq_pend;
      irq_valid  <= |next_irq_pend;
      irq_vector <= next_vector; // R11
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_float     <= 1'b0;
      p0_push_pull  <= 1'b1;
      p1_push_pull  <= 1'b1;
      port_std_buf  <= 4'hF;
      osc_std_drive <= 1'b1;
      osc_limit_err <= 1'b0;
    end else begin
      bus_float     <= bus_float_reg; // R4
      p1_push_pull  <= port_config_reg[pce_pkg::CFG_P1_PP]; // R15
      p0_push_pull  <= port_config_reg[pce_pkg::CFG_P0_PP]; // R16
      port_std_buf  <= port_config_reg[pce_pkg::CFG_P3_STD:pce_pkg::CFG_P0_STD]; // R17
      osc_std_drive <= port_config_reg[pce_pkg::CFG_OSC_STD]; // R18
      // flag only; the block cannot change the clock rate itself
      osc_limit_err <= sclk_above_2mhz & ~port_config_reg[pce_pkg::CFG_OSC_STD]; // R21
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (bus_req.addr == pce_pkg::ADDR_PORT_CONFIG) begin
      next_rdata = port_config_reg;
    end else if (bus_req.addr == pce_pkg::ADDR_PORT3_MODE) begin
      next_rdata = port3_mode_reg;
    end else if (bus_req.addr == pce_pkg::ADDR_P2_DIR) begin
      next_rdata = p2_dir;
    end else if (bus_req.addr == pce_pkg::ADDR_P2_OUT) begin
      next_rdata = p2_data;
    end else if (bus_req.addr == pce_pkg::ADDR_P2_IN) begin
      next_rdata = p2_in; // R1
    end else if (bus_req.addr == pce_pkg::ADDR_P3_OUT) begin
      next_rdata = p3_data;
    end else if (bus_req.addr == pce_pkg::ADDR_P3_IN) begin
      next_rdata = port3_mode_reg[pce_pkg::P3M_ANALOG] ?
        {p3_lines[7:3], cmp2_result, cmp1_result, p3_lines[0]} : p3_lines; // R12
    end else if (bus_req.addr == pce_pkg::ADDR_IRQ_PEND) begin
      next_rdata = {2'h0, irq_pend};
    end else if (bus_req.addr == pce_pkg::ADDR_EDGE_SEL) begin
      next_rdata = {4'h0, edge_sel};
    end else if (bus_req.addr == pce_pkg::ADDR_BUS_CTRL) begin
      next_rdata = {7'h00, bus_float_reg};
    end else if (bus_req.addr == pce_pkg::ADDR_P1_DIR) begin
      next_rdata = p1_dir;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : pce_port_cfg
`default_nettype wire

// [src/pce_pkg.sv]
// package: register map, field positions and types for the port configuration block
package pce_pkg;
  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_PORT_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_PORT3_MODE  = 4'h1;
  localparam logic [3:0] ADDR_P2_DIR      = 4'h2;
  localparam logic [3:0] ADDR_P2_OUT      = 4'h3;
  localparam logic [3:0] ADDR_P2_IN       = 4'h4;
  localparam logic [3:0] ADDR_P3_OUT      = 4'h5;
  localparam logic [3:0] ADDR_P3_IN       = 4'h6;
  localparam logic [3:0] ADDR_IRQ_PEND    = 4'h7;
  localparam logic [3:0] ADDR_EDGE_SEL    = 4'h8;
  localparam logic [3:0] ADDR_BUS_CTRL    = 4'h9;
  localparam logic [3:0] ADDR_P1_DIR      = 4'hA;
  // ---------------------------------------------------------------
  // port_config fields
  // ---------------------------------------------------------------
  localparam int CFG_CMP_OUT   = 0;
  localparam int CFG_P1_PP     = 1;
  localparam int CFG_P0_PP     = 2;
  localparam int CFG_P0_STD    = 3;
  localparam int CFG_P1_STD    = 4;
  localparam int CFG_P2_STD    = 5;
  localparam int CFG_P3_STD    = 6;
  localparam int CFG_OSC_STD   = 7;
  localparam logic [7:0] PORT_CONFIG_RST = 8'hFE;
  // ---------------------------------------------------------------
  // port3_mode_reg fields and other resets
  // ---------------------------------------------------------------
  localparam int P3M_P2_OD      = 0;
  localparam int P3M_ANALOG     = 1;
  localparam int P3M_HSK_EN     = 2;
  localparam logic [7:0] PORT3_MODE_RST = 8'h00;
  localparam logic [7:0] P2_DIR_RST     = 8'hFF;
  localparam logic [7:0] P1_DIR_RST     = 8'hFF;
  localparam logic [3:0] EDGE_SEL_RST   = 4'h0;
  // ---------------------------------------------------------------
  // edge modes and vectors
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PCE_EDGE_FALL, PCE_EDGE_RISE, PCE_EDGE_BOTH, PCE_EDGE_BOTH2
  } pce_edge_e;
  localparam logic [3:0] VEC_IRQ0 = 4'h0;
  localparam logic [3:0] VEC_IRQ1 = 4'h2;
  localparam logic [3:0] VEC_IRQ2 = 4'h4;
  localparam logic [3:0] VEC_IRQ3 = 4'h6;
  localparam logic [3:0] VEC_IRQ4 = 4'h8;
  localparam logic [3:0] VEC_IRQ5 = 4'hA;
  localparam int NUM_IRQ = 6;
  // ---------------------------------------------------------------
  // bus carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pce_req_s;
endpackage : pce_pkg

// [src/pce_edge_det.sv]
// module: one edge detector with selectable edge polarity
`timescale 1ns/10ps
`default_nettype none
module pce_edge_det (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  output logic            hit
);
  logic prev;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 1'b1;
      hit  <= 1'b0;
    end else begin
      prev <= pin;
      case (pce_pkg::pce_edge_e'(mode))
        pce_pkg::PCE_EDGE_FALL: hit <= prev & ~pin;
        pce_pkg::PCE_EDGE_RISE: hit <= ~prev & pin;
        default:                hit <= prev ^ pin;
      endcase
    end
  end
endmodule : pce_edge_det
`default_nettype wire

// [dv/pce_port_cfg_sva.sv]
// checker: timing and field properties at the port configuration block ports
`timescale 1ns/10ps
`default_nettype none
module pce_port_cfg_sva (
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire pce_pkg::pce_req_s bus_req,
  input wire logic              rom_mode,
  input wire logic [7:0]        p2_oe,
  input wire logic [7:0]        p3_in,
  input wire logic              timer1_in,
  input wire logic [2:0]        hsk_in,
  input wire logic [5:0]        irq_req,
  input wire logic              irq_valid,
  input wire logic [3:0]        irq_vector,
  input wire logic [7:0]        p1_dir,
  input wire logic              bus_float,
  input wire logic              p0_push_pull,
  input wire logic              p1_push_pull,
  input wire logic [3:0]        port_std_buf,
  input wire logic              osc_std_drive
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire cfg_wr = bus_req.wr && bus_req.addr == pce_pkg::ADDR_PORT_CONFIG;
  wire p1_wr  = bus_req.wr && bus_req.addr == pce_pkg::ADDR_P1_DIR;

  AST_CFG_DRIVE: assert property (cfg_wr |-> ##2 p1_push_pull == $past(bus_req.wdata[1], 2)
    && p0_push_pull == $past(bus_req.wdata[2], 2)) else $error("drive fields not taken");
  AST_CFG_BUF: assert property (cfg_wr |-> ##2 port_std_buf == $past(bus_req.wdata[6:3], 2)
    && osc_std_drive == $past(bus_req.wdata[7], 2)) else $error("buffer fields not taken");
  AST_RST_DEF: assert property ($rose(reset_n) |-> p0_push_pull && p1_push_pull && osc_std_drive
    && port_std_buf == 4'hF && p2_oe == 8'h00 && p1_dir == 8'hFF) else $error("reset defaults wrong");
  AST_ROM_P1: assert property (rom_mode && p1_wr |-> ##2 p1_dir == $past(p1_dir, 2))
    else $error("port 1 direction changed in rom mode");
  AST_FLOAT: assert property (bus_float && $past(bus_float) |-> p2_oe == 8'h00)
    else $error("port 2 driven while floating");
  AST_TMR_IN: assert property ($past(reset_n, 2) |-> timer1_in == $past(p3_in[1], 2))
    else $error("timer input path wrong");
  AST_HSK_IN: assert property ($past(reset_n, 2) |-> hsk_in == $past(p3_in[2:0], 2))
    else $error("handshake input path wrong");
  AST_IRQ_FALL: assert property ($past(reset_n, 3) && $fell(p3_in[0]) |-> ##3 irq_req[3])
    else $error("falling edge request missing");
  AST_VEC: assert property (irq_req[0] && $past(irq_req[0]) |-> irq_valid
    && irq_vector == pce_pkg::VEC_IRQ0) else $error("vector not lowest");

  cover property (cfg_wr ##2 !osc_std_drive);
  cover property (irq_valid && irq_vector == pce_pkg::VEC_IRQ4);
  cover property (bus_float);
endmodule : pce_port_cfg_sva

bind pce_port_cfg pce_port_cfg_sva u_pce_port_cfg_sva (.ref_clk, .reset_n, .bus_req, .rom_mode, .p2_oe,
  .p3_in, .timer1_in, .hsk_in, .irq_req, .irq_valid, .irq_vector, .p1_dir, .bus_float, .p0_push_pull,
  .p1_push_pull, .port_std_buf, .osc_std_drive);
`default_nettype wire

// [dv/pce_pin_model.sv]
// model: pin levels of ports 2 and 3 as seen from outside the block
`timescale 1ns/10ps
`default_nettype none
module pce_pin_model (
  input  wire logic [7:0] p2_out,
  input  wire logic [7:0] p2_oe,
  input  wire logic [7:0] p2_ext,
  input  wire logic [7:0] p3_out,
  input  wire logic [7:0] p3_oe,
  input  wire logic [7:0] p3_ext,
  output logic [7:0]      p2_in,
  output logic [7:0]      p3_in
);
  // ---------------------------------------------------------------
  // resolution
  // ---------------------------------------------------------------
  // released lines on ports 2 and 3 fall back to the external level
  assign p2_in = (p2_out & p2_oe) | (p2_ext & ~p2_oe);
  assign p3_in = (p3_out & p3_oe) | (p3_ext & ~p3_oe);
endmodule : pce_pin_model
`default_nettype wire

// [dv/pce_port_cfg_bench.sv]
// testbench: register, pin, interrupt and configuration scenarios
`timescale 1ns/10ps
`default_nettype none
module pce_port_cfg_bench;
  logic ref_clk = 1'b0, reset_n = 1'b0, rom_mode = 1'b0, cmp1_result = 1'b0, cmp2_result = 1'b1;
  logic timer1_out = 1'b0, sclk_above_2mhz = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [2:0] hsk_out = 3'h0;
  logic [7:0] p2_ext = 8'hFF, p3_ext = 8'h0F;
  pce_pkg::pce_req_s bus_req = '0;
  logic [7:0] rdata, p2_in, p2_out, p2_oe, p3_in, p3_out, p3_oe, p1_dir;
  logic [5:0] irq_req;
  logic [3:0] irq_vector, port_std_buf;
  logic [2:0] hsk_in;
  logic analog_en, timer1_in, irq_valid, bus_float, p0_push_pull, p1_push_pull, osc_std_drive, osc_limit_err;
  int failures = 0, check_count = 0;
  always #5 ref_clk = ~ref_clk;

  pce_port_cfg u_pce_port_cfg (.ref_clk, .reset_n, .bus_req, .rdata, .rom_mode, .p2_in, .p2_out, .p2_oe,
    .p3_in, .p3_out, .p3_oe, .cmp1_result, .cmp2_result, .analog_en, .timer1_out, .timer1_in,
    .data_available_0(ev[3]), .data_available_2(ev[2]), .counter_zero(ev[0]), .counter_one(ev[1]),
    .hsk_out, .hsk_in, .irq_req, .irq_valid, .irq_vector, .p1_dir, .bus_float, .p0_push_pull,
    .p1_push_pull, .port_std_buf, .osc_std_drive, .osc_limit_err, .sclk_above_2mhz);
  pce_pin_model u_pce_pin_model (.p2_out, .p2_oe, .p2_ext, .p3_out, .p3_oe, .p3_ext, .p2_in, .p3_in);

  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus_req <= {a, d, 2'b10};
    @(posedge ref_clk) bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk) bus_req <= {a, 8'h00, 2'b01};
    @(posedge ref_clk) bus_req <= '0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic clr;
    wr(pce_pkg::ADDR_IRQ_PEND, 8'hFF);
    cyc(3);
  endtask : clr
  task automatic pin3(input logic [7:0] v);
    @(posedge ref_clk) p3_ext <= v;
    cyc(4);
  endtask : pin3

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(pce_pkg::ADDR_PORT_CONFIG, pce_pkg::PORT_CONFIG_RST);
    chk(p2_oe, 8'h00);
    rd(pce_pkg::ADDR_P2_DIR, pce_pkg::P2_DIR_RST);
    chk({p0_push_pull, p1_push_pull, osc_std_drive, 1'b0, port_std_buf}, 8'hEF);
    rd(4'hB, 8'h00);
  endtask : t_reset
  task automatic t_cfg;
    wr(pce_pkg::ADDR_PORT_CONFIG, 8'h01);
    @(posedge ref_clk) begin sclk_above_2mhz <= 1'b1; cmp1_result <= 1'b1; cmp2_result <= 1'b0; end
    cyc(3);
    chk({p0_push_pull, p1_push_pull, osc_std_drive, 1'b0, port_std_buf}, 8'h00);
    chk({7'h0, osc_limit_err}, 8'h01);
    chk({6'h0, p3_out[7], p3_out[4]}, 8'h01);
    rd(pce_pkg::ADDR_PORT_CONFIG, 8'h01);
    wr(pce_pkg::ADDR_PORT_CONFIG, 8'hFE);
    cyc(3);
    chk({6'h0, p3_out[7], p3_out[4]}, 8'h00);
    chk({7'h0, osc_limit_err}, 8'h00);
    @(posedge ref_clk) sclk_above_2mhz <= 1'b0;
  endtask : t_cfg
  task automatic t_port2;
    wr(pce_pkg::ADDR_P2_DIR, 8'h00);
    wr(pce_pkg::ADDR_P2_OUT, 8'hA5);
    cyc(3);
    chk(p2_oe, 8'hFF);
    rd(pce_pkg::ADDR_P2_IN, 8'hA5);
    wr(pce_pkg::ADDR_P2_DIR, 8'h0F);
    wr(pce_pkg::ADDR_PORT3_MODE, 8'h01);
    cyc(3);
    chk(p2_oe, 8'h50);
    rd(pce_pkg::ADDR_P2_IN, 8'hAF);
    wr(pce_pkg::ADDR_BUS_CTRL, 8'h01);
    cyc(3);
    chk({7'h0, bus_float}, 8'h01);
    chk(p2_oe, 8'h00);
    wr(pce_pkg::ADDR_BUS_CTRL, 8'h00);
    wr(pce_pkg::ADDR_PORT3_MODE, 8'h00);
    wr(pce_pkg::ADDR_P2_DIR, 8'hFF);
  endtask : t_port2
  task automatic t_irq;
    logic [5:0] er [4] = '{6'h10, 6'h30, 6'h34, 6'h35};
    logic [3:0] ev_vec [4] = '{pce_pkg::VEC_IRQ4, pce_pkg::VEC_IRQ4, pce_pkg::VEC_IRQ2, pce_pkg::VEC_IRQ0};
    pin3(8'h0E);
    chk({irq_valid, 1'b0, irq_req}, 8'h88);
    chk({4'h0, irq_vector}, {4'h0, pce_pkg::VEC_IRQ3});
    clr;
    pin3(8'h0F);
    chk({irq_valid, 1'b0, irq_req}, 8'h00);
    pin3(8'h07);
    chk({irq_valid, 1'b0, irq_req}, 8'h82);
    chk({4'h0, irq_vector}, {4'h0, pce_pkg::VEC_IRQ1});
    clr;
    pin3(8'h0F);
    chk({irq_valid, 1'b0, irq_req}, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(pce_pkg::ADDR_EDGE_SEL, {4'h0, m[1:0], m[1:0]});
      pin3(8'h09);
      chk({irq_valid, 1'b0, irq_req}, (m != 1) ? 8'h85 : 8'h00);
      clr;
      pin3(8'h0F);
      chk({irq_valid, 1'b0, irq_req}, (m != 0) ? 8'h85 : 8'h00);
      clr;
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk) ev <= 4'h1 << k;
      @(posedge ref_clk) ev <= 4'h0;
      cyc(3);
      chk({irq_valid, 1'b0, irq_req}, {2'b10, er[k]});
      chk({4'h0, irq_vector}, {4'h0, ev_vec[k]});
    end
    clr;
    chk({irq_valid, 1'b0, irq_req}, 8'h00);
  endtask : t_irq
  task automatic t_port3;
    @(posedge ref_clk) begin timer1_out <= 1'b1; hsk_out <= 3'b101; end
    wr(pce_pkg::ADDR_PORT3_MODE, 8'h04);
    cyc(3);
    chk({5'h0, p3_out[7], p3_out[5], p3_out[4]}, 8'h05);
    chk({7'h0, p3_out[6]}, 8'h01);
    chk(p3_oe, 8'hF0);
    wr(pce_pkg::ADDR_PORT3_MODE, 8'h02);
    cyc(3);
    chk({7'h0, analog_en}, 8'h01);
    chk({irq_valid, 1'b0, irq_req}, 8'h81);
    rd(pce_pkg::ADDR_P3_IN, 8'h4B);
    clr;
    chk({irq_valid, 1'b0, irq_req}, 8'h00);
    wr(pce_pkg::ADDR_PORT3_MODE, 8'h00);
    cyc(3);
    clr;
  endtask : t_port3
  task automatic t_rom;
    @(posedge ref_clk) rom_mode <= 1'b1;
    wr(pce_pkg::ADDR_P1_DIR, 8'h00);
    cyc(3);
    chk(p1_dir, 8'hFF);
    @(posedge ref_clk) rom_mode <= 1'b0;
    wr(pce_pkg::ADDR_P1_DIR, 8'h3C);
    cyc(3);
    chk(p1_dir, 8'h3C);
  endtask : t_rom
  task automatic end_of_test;
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset;
    t_cfg;
    t_port2;
    t_irq;
    t_port3;
    t_rom;
    @(posedge ref_clk) reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset;
    end_of_test;
  end
  // whole run is well under a thousand cycles
  initial begin
    #50000;
    failures++;
    end_of_test;
  end
endmodule : pce_port_cfg_bench
`default_nettype wire
